/* rtl/rtcc_pkg.sv */
// Package of constants for the calendar time count registers
package rtcc_pkg;
	// Register addresses in I/O space
	localparam logic [7:0] RTCC_OFS_SECONDS = 8'he0;
	localparam logic [7:0] RTCC_OFS_MINUTES = 8'he1;
	localparam logic [7:0] RTCC_OFS_HOURS = 8'he2;
	localparam logic [7:0] RTCC_OFS_WEEKDAY = 8'he3;
	localparam logic [7:0] RTCC_OFS_MONTHDAY = 8'he4;
	// Limits of each count, binary form
	localparam logic [7:0] RTCC_SEC_MAX = 8'h3b;
	localparam logic [7:0] RTCC_MIN_MAX = 8'h3b;
	localparam logic [7:0] RTCC_HOUR_MAX = 8'h17;
	localparam logic [3:0] RTCC_WDAY_MIN = 4'h1;
	localparam logic [3:0] RTCC_WDAY_MAX = 4'h7;
	localparam logic [7:0] RTCC_MDAY_MIN = 8'h01;
	localparam logic [3:0] RTCC_WDAY_RSVD = 4'h0;
	// Timebase figures
	localparam int RTCC_XTAL_HZ = 32768;
	localparam int RTCC_LINE50_HZ = 50;
	localparam int RTCC_LINE60_HZ = 60;
	localparam logic [15:0] RTCC_XTAL_DIV = 16'(RTCC_XTAL_HZ - 1);
	localparam logic [15:0] RTCC_L50_DIV = 16'(RTCC_LINE50_HZ - 1);
	localparam logic [15:0] RTCC_L60_DIV = 16'(RTCC_LINE60_HZ - 1);
	localparam logic [15:0] RTCC_DIV_RESET = 16'h0000;
	// Timebase sources
	typedef enum logic [1:0] {
		RTCC_SRC_XTAL = 2'h0,
		RTCC_SRC_LINE50 = 2'h1,
		RTCC_SRC_LINE60 = 2'h2
	} rtcc_src_t;
endpackage

/* rtl/rtcc_divider.sv */
// Timebase divider producing one pulse per second
module rtcc_divider (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic restart,
	input wire logic run,
	input wire logic src_edge,
	input wire rtcc_pkg::rtcc_src_t src_sel,
	output logic tick
);
	import rtcc_pkg::*;

	logic [15:0] count;
	logic [15:0] next_count;
	logic next_tick;
	logic [15:0] limit;

	// Next divider phase; restart wins so each control write starts a fresh second
	always_comb begin
		limit = (src_sel == RTCC_SRC_LINE50) ? RTCC_L50_DIV :
			(src_sel == RTCC_SRC_LINE60) ? RTCC_L60_DIV : RTCC_XTAL_DIV;
		next_count = count;
		next_tick = 1'b0;
		if (restart) begin
			next_count = RTCC_DIV_RESET;
		end else if (run && src_edge) begin
			if (count >= limit) begin
				next_count = RTCC_DIV_RESET;
				next_tick = 1'b1;
			end else begin
				next_count = count + 16'h0001;
			end
		end
	end

	// Register the divider
	always_ff @(posedge core_clk) begin
		if (reset) begin
			count <= RTCC_DIV_RESET;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule

/* rtl/rtcc_time_count.sv */
// Calendar time count registers: seconds, minutes, hours, weekday, day of month
// Behaviour
// - After power-down reset the counts are undefined until software loads them.
// - Clearing the unlock bit restarts the timebase divider from a fresh phase.
// - Unlocked: counting stops and all count registers are readable and writable.
// - Locked: counts advance and count registers are read-only.
// - Chip reset locks the block, enabling counting.
// - Chip reset leaves the count registers and weekday low nibble untouched.
// - Format select chooses pure binary or packed two-digit BCD.
// - Seconds run 0 to 59, BCD tens in [7:4], ones in [3:0].
// - Minutes run 0 to 59 in either format.
// - Hours run 0 to 23 in either format.
// - Weekday uses low nibble 1 to 7; upper nibble reads zero.
// - Day of month starts at one; BCD tens 0 to 3.
// - Count registers are I/O locations on the on-chip address and data bus.
// - Hours are kept in 24-hour form only.
// - Month-day rolls over by month length; leap years only in BCD.
// - Any control write restarts the divider; it gives one tick per second.

// Interface notes
// The control register lives outside this block; its lock bit, format bit and
// source choice arrive as levels, and ctrl_wr pulses whenever it is written.
// Month and leap-year state come from the calendar logic above the day count.
// Counts carry no reset, so a chip reset never disturbs the time of day.
// Reads are registered: data and hit appear one cycle after the read strobe.
// Lock and counting hang off one bit, so a CPU write can never race a tick.
// Binary mode never sees February 29th, so a leap year needs BCD mode.
// Values loaded out of range are not repaired until their count wraps.
module rtcc_time_count (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic ctrl_wr,
	input wire logic count_write_permit,
	input wire logic decimal_format_select,
	input wire rtcc_pkg::rtcc_src_t timebase_choice,
	input wire logic timebase_edge,
	input wire logic [7:0] month_count,
	input wire logic leap_year,
	output logic [7:0] io_rdata,
	output logic io_hit,
	output logic second_tick
);
	import rtcc_pkg::*;

	// ****************************************
	// Functions
	// ****************************************

	// Increment in the chosen format; returns wrap value past max
	function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] maxb,
		input logic [7:0] wrapv, input logic bcd);
		logic [7:0] r;
		r = 8'h00;
		if (bcd) begin
			// Compare against the limit in BCD so both formats share one table
			if (v == bin2bcd(maxb)) begin
				r = wrapv;
			end else if (v[3:0] >= 4'h9) begin
				// Ones digit rolls over and carries into the tens digit
				r = {v[7:4] + 4'h1, 4'h0};
			end else begin
				r = v + 8'h01;
			end
		end else begin
			// A value past the limit also wraps, so a bad load heals itself
			r = (v >= maxb) ? wrapv : v + 8'h01;
		end
		return r;
	endfunction

	// True for the five count addresses; used by the write decode only, the read mux compares each address
	function automatic logic is_count_addr(input logic [7:0] a);
		logic r;
		r = 1'b0;
		if (a >= RTCC_OFS_SECONDS && a <= RTCC_OFS_MONTHDAY) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// Weekday steps 1..7; a stray value outside that range is pulled back to one
	function automatic logic [3:0] wday_step(input logic [3:0] w);
		logic [3:0] r;
		r = RTCC_WDAY_MIN;
		if (w >= RTCC_WDAY_MIN && w < RTCC_WDAY_MAX) begin
			r = w + 4'h1;
		end
		return r;
	endfunction

	// Convert a binary limit below 100 to packed BCD
	function automatic logic [7:0] bin2bcd(input logic [7:0] b);
		logic [7:0] t;
		logic [7:0] o;
		t = b / 8'd10;
		o = b % 8'd10;
		return {t[3:0], o[3:0]};
	endfunction

	// Days in the current month; month count is in the chosen format
	function automatic logic [7:0] month_days(input logic [7:0] m, input logic bcd,
		input logic leap);
		logic [7:0] mb;
		logic [7:0] d;
		mb = m;
		if (bcd) begin
			// Widen the tens digit first so the product keeps all its bits
			mb = ({4'h0, m[7:4]} * 8'd10) + {4'h0, m[3:0]};
		end
		d = 8'd31;
		if (mb == 8'd4 || mb == 8'd6 || mb == 8'd9 || mb == 8'd11) begin
			d = 8'd30;
		end else if (mb == 8'd2) begin
			d = (bcd && leap) ? 8'd29 : 8'd28;
		end
		return d;
	endfunction

	// ****************************************
	// State
	// ****************************************

	// Counts have no reset so a chip reset keeps the time (and undefined after power-up)
	logic [7:0] seconds_count;
	logic [7:0] minutes_count;
	logic [7:0] hours_count;
	logic [3:0] weekday_value;
	logic [7:0] monthday_count;
	logic [7:0] next_seconds;
	logic [7:0] next_minutes;
	logic [7:0] next_hours;
	logic [3:0] next_weekday;
	logic [7:0] next_monthday;
	logic [7:0] next_rdata;
	logic next_hit;
	logic permit_q;
	logic restart;
	logic tick;
	logic unlocked;
	logic count_en;
	logic sec_wrap;
	logic min_wrap;
	logic hour_wrap;

	// ****************************************
	// Lock control
	// ****************************************

	// Locked after reset: permit is only honoured once the block has seen it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			permit_q <= 1'b0;
		end else begin
			permit_q <= count_write_permit;
		end
	end

	assign unlocked = permit_q;
	assign count_en = ~permit_q;
	// Falling permit or any control write restarts the divider
	assign restart = ctrl_wr | (permit_q & ~count_write_permit);

	rtcc_divider u_divider (
		.core_clk(core_clk),
		.reset(reset),
		.restart(restart),
		.run(count_en),
		.src_edge(timebase_edge),
		.src_sel(timebase_choice),
		.tick(tick)
	);

	// ****************************************
	// Counting and CPU writes
	// ****************************************

	// Next counts: CPU writes when unlocked, carry chain when locked.
	// Both branches hang off the registered lock bit, so they never overlap;
	// the carry chain looks at the freshly stepped values, which lets one
	// tick ripple from seconds all the way to the day of month.
	always_comb begin
		logic [7:0] mdays;
		mdays = month_days(month_count, decimal_format_select, leap_year);
		sec_wrap = 1'b0;
		min_wrap = 1'b0;
		hour_wrap = 1'b0;
		next_seconds = seconds_count;
		next_minutes = minutes_count;
		next_hours = hours_count;
		next_weekday = weekday_value;
		next_monthday = monthday_count;
		if (unlocked && io_wr && is_count_addr(io_addr)) begin
			// Locked writes fall through unchanged, so they are dropped
			if (io_addr == RTCC_OFS_SECONDS) begin
				next_seconds = io_wdata;
			end else if (io_addr == RTCC_OFS_MINUTES) begin
				next_minutes = io_wdata;
			end else if (io_addr == RTCC_OFS_HOURS) begin
				next_hours = io_wdata;
			end else if (io_addr == RTCC_OFS_WEEKDAY) begin
				next_weekday = io_wdata[3:0];
			end else if (io_addr == RTCC_OFS_MONTHDAY) begin
				next_monthday = io_wdata;
			end
		end else if (count_en && tick) begin
			next_seconds = step(seconds_count, RTCC_SEC_MAX, 8'h00,
				decimal_format_select);
			// A wrap of each count is the carry into the next one up
			sec_wrap = (next_seconds == 8'h00);
			if (sec_wrap) begin
				next_minutes = step(minutes_count, RTCC_MIN_MAX, 8'h00,
					decimal_format_select);
				min_wrap = (next_minutes == 8'h00);
				if (min_wrap) begin
					// 24-hour wrap, no morning/afternoon flag
					next_hours = step(hours_count, RTCC_HOUR_MAX, 8'h00,
						decimal_format_select);
					hour_wrap = (next_hours == 8'h00);
					if (hour_wrap) begin
						next_weekday = wday_step(weekday_value);
						next_monthday = step(monthday_count, mdays, RTCC_MDAY_MIN,
							decimal_format_select);
					end
				end
			end
		end
	end

	// Counts carry no reset term, so a chip reset leaves them as they were.
	// The price is unknown values after power-up; software must load them
	// before the first lock, or the carry chain counts from garbage.
	always_ff @(posedge core_clk) begin
		seconds_count <= next_seconds;
		minutes_count <= next_minutes;
		hours_count <= next_hours;
		weekday_value <= next_weekday;
		monthday_count <= next_monthday;
	end

	// ****************************************
	// CPU reads
	// ****************************************

	// Read mux over the I/O addresses of the counts.
	// Reads are allowed in both lock states; an unmapped address answers
	// with zero data and no hit, so a shared bus can tell who replied.
	always_comb begin
		next_rdata = 8'h00;
		next_hit = 1'b0;
		if (io_rd) begin
			if (io_addr == RTCC_OFS_SECONDS) begin
				next_rdata = seconds_count;
				next_hit = 1'b1;
			end else if (io_addr == RTCC_OFS_MINUTES) begin
				next_rdata = minutes_count;
				next_hit = 1'b1;
			end else if (io_addr == RTCC_OFS_HOURS) begin
				next_rdata = hours_count;
				next_hit = 1'b1;
			end else if (io_addr == RTCC_OFS_WEEKDAY) begin
				next_rdata = {RTCC_WDAY_RSVD, weekday_value};
				next_hit = 1'b1;
			end else if (io_addr == RTCC_OFS_MONTHDAY) begin
				next_rdata = monthday_count;
				next_hit = 1'b1;
			end
		end
	end

	// Registered read data and tick out
	always_ff @(posedge core_clk) begin
		if (reset) begin
			io_rdata <= 8'h00;
			io_hit <= 1'b0;
			second_tick <= 1'b0;
		end else begin
			io_rdata <= next_rdata;
			io_hit <= next_hit;
			second_tick <= count_en & tick;
		end
	end
endmodule

/* tb/rtcc_time_count_props.sv */
// Checker of the bus and tick behaviour of the time count registers
module rtcc_time_count_chk import rtcc_pkg::*; (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic ctrl_wr,
	input wire logic count_write_permit,
	input wire logic decimal_format_select,
	input wire rtcc_pkg::rtcc_src_t timebase_choice,
	input wire logic timebase_edge,
	input wire logic [7:0] month_count,
	input wire logic leap_year,
	input wire logic [7:0] io_rdata,
	input wire logic io_hit,
	input wire logic second_tick
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	// ****************************************
	// Read sequences
	// ****************************************
	sequence s_cnt_rd;
		io_rd && io_addr >= RTCC_OFS_SECONDS && io_addr <= RTCC_OFS_MONTHDAY;
	endsequence
	sequence s_bin_rd(logic [7:0] a);
		io_rd && io_addr == a && !decimal_format_select;
	endsequence
	a_read_hit: assert property (s_cnt_rd |=> io_hit)
		else $error("count read gave no hit");
	a_miss_quiet: assert property (io_rd && (io_addr < RTCC_OFS_SECONDS ||
		io_addr > RTCC_OFS_MONTHDAY) |=> !io_hit)
		else $error("unmapped read gave a hit");
	a_hit_needs_read: assert property (!io_rd |=> !io_hit)
		else $error("hit without a read");
	a_idle_zero: assert property (!io_hit |-> io_rdata == 8'h00)
		else $error("read data not zero when idle");
	a_wday_upper: assert property (io_rd && io_addr == RTCC_OFS_WEEKDAY |=> io_rdata[7:4] == 4'h0)
		else $error("weekday upper nibble not zero");
	a_sec_range: assert property (s_bin_rd(RTCC_OFS_SECONDS) |=> io_rdata <= RTCC_SEC_MAX)
		else $error("seconds out of range");
	a_hour_range: assert property (s_bin_rd(RTCC_OFS_HOURS) |=> io_rdata <= RTCC_HOUR_MAX)
		else $error("hours out of range");
	a_tick_single: assert property (second_tick |=> !second_tick)
		else $error("second tick longer than one cycle");
	// Permit is registered, so allow the pipeline to settle first
	a_stop_unlocked: assert property (count_write_permit [*4] |-> !second_tick)
		else $error("tick while unlocked");
endmodule
bind rtcc_time_count rtcc_time_count_chk u_chk (.core_clk(core_clk), .reset(reset),
	.io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .ctrl_wr(ctrl_wr),
	.count_write_permit(count_write_permit), .decimal_format_select(decimal_format_select),
	.timebase_choice(timebase_choice), .timebase_edge(timebase_edge),
	.month_count(month_count), .leap_year(leap_year), .io_rdata(io_rdata), .io_hit(io_hit),
	.second_tick(second_tick));

/* tb/tb_rtcc_time_count.sv */
// Self-checking testbench of the time count registers
module tb_rtcc_time_count import rtcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, reset = 1, io_wr = 0, io_rd = 0, ctrl_wr = 0, permit = 0;
	logic dec = 0, tb_edge = 0, leap = 0, hit, tick;
	logic [7:0] addr = 8'h00, wdata = 8'h00, month = 8'h01, rdata, v;
	rtcc_src_t src = RTCC_SRC_LINE50;
	logic [31:0] seed = 32'h29850daf;
	int failures = 0, num_checks = 0, cyc = 0, ticks = 0, n = 0;
	rtcc_time_count dut (.core_clk(core_clk), .reset(reset), .io_addr(addr), .io_wdata(wdata),
		.io_wr(io_wr), .io_rd(io_rd), .ctrl_wr(ctrl_wr), .count_write_permit(permit),
		.decimal_format_select(dec), .timebase_choice(src), .timebase_edge(tb_edge),
		.month_count(month), .leap_year(leap), .io_rdata(rdata), .io_hit(hit),
		.second_tick(tick));
	always #5 core_clk = ~core_clk;
	// Count ticks; cut a hang short well past the expected run length
	always @(posedge core_clk) begin
		cyc++;
		if (tick === 1'b1) ticks++;
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge core_clk);
		addr = a;
		wdata = d;
		io_wr = 1;
		@(negedge core_clk);
		io_wr = 0;
	endtask
	// Answer stands one cycle, so it is sampled at the next falling edge
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(negedge core_clk);
		addr = a;
		io_rd = 1;
		@(negedge core_clk);
		io_rd = 0;
		check("hit", {7'h0, a >= RTCC_OFS_SECONDS && a <= RTCC_OFS_MONTHDAY}, {7'h0, hit});
		check("rdata", e, rdata);
	endtask
	// Feed timebase pulses until one second passes, bounded
	task automatic sec_tick(output int cnt);
		int t0;
		t0 = ticks;
		cnt = 0;
		for (int i = 0; i < 200 && ticks == t0; i++) begin
			@(negedge core_clk) tb_edge = 1;
			@(negedge core_clk) tb_edge = 0;
			cnt++;
		end
		repeat (2) @(negedge core_clk);
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge core_clk);
		reset = 0;
		// ****************************************
		// Unlocked write and read back
		// ****************************************
		permit = 1;
		for (int i = 0; i < 8; i++) begin
			v = 8'(rnd() % 60);
			wr(RTCC_OFS_SECONDS, v);
			rd(RTCC_OFS_SECONDS, v);
		end
		rd(8'he5, 8'h00);
		$display("test unlocked access done");
		// Binary rollover of every count, with a refused locked write
		wr(RTCC_OFS_SECONDS, 8'h3b);
		wr(RTCC_OFS_MINUTES, 8'h3b);
		wr(RTCC_OFS_HOURS, 8'h17);
		wr(RTCC_OFS_WEEKDAY, 8'h07);
		wr(RTCC_OFS_MONTHDAY, 8'h1f);
		permit = 0;
		wr(RTCC_OFS_SECONDS, 8'h05);
		rd(RTCC_OFS_SECONDS, 8'h3b);
		sec_tick(n);
		rd(RTCC_OFS_SECONDS, 8'h00);
		rd(RTCC_OFS_MINUTES, 8'h00);
		rd(RTCC_OFS_HOURS, 8'h00);
		rd(RTCC_OFS_WEEKDAY, 8'h01);
		rd(RTCC_OFS_MONTHDAY, 8'h01);
		$display("test binary rollover done");
		// BCD carry and a short February
		permit = 1;
		dec = 1;
		month = 8'h02;
		wr(RTCC_OFS_SECONDS, 8'h59);
		wr(RTCC_OFS_MINUTES, 8'h59);
		wr(RTCC_OFS_MONTHDAY, 8'h28);
		wr(RTCC_OFS_HOURS, 8'h23);
		permit = 0;
		sec_tick(n);
		rd(RTCC_OFS_SECONDS, 8'h00);
		rd(RTCC_OFS_MINUTES, 8'h00);
		rd(RTCC_OFS_MONTHDAY, 8'h01);
		rd(RTCC_OFS_HOURS, 8'h00);
		$display("test bcd rollover done");
		// Chip reset keeps counts and locks the block
		reset = 1;
		repeat (2) @(negedge core_clk);
		reset = 0;
		rd(RTCC_OFS_MINUTES, 8'h00);
		rd(RTCC_OFS_MONTHDAY, 8'h01);
		wr(RTCC_OFS_SECONDS, 8'h33);
		rd(RTCC_OFS_SECONDS, 8'h00);
		sec_tick(n);
		rd(RTCC_OFS_SECONDS, 8'h01);
		$display("test reset done");
		// Control write mid-second restarts the 60 Hz divider from zero
		src = RTCC_SRC_LINE60;
		repeat (30) begin
			@(negedge core_clk) tb_edge = 1;
			@(negedge core_clk) tb_edge = 0;
		end
		@(negedge core_clk) ctrl_wr = 1;
		@(negedge core_clk) ctrl_wr = 0;
		sec_tick(n);
		// The loop sees the tick one pulse after the last divided one
		check("edges", 8'(RTCC_LINE60_HZ + 1), 8'(n));
		rd(RTCC_OFS_SECONDS, 8'h02);
		$display("test divider restart done");
		finish_test();
	end
endmodule
